// *** hdl/ccr_defines.svh ***
/*
  Offsets, field positions, key values and timing counts of the CPU core
  control registers. Assumes a 6-bit I/O byte address from the core.
*/
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CCR_OFS_GUARD       6'h04
`define CCR_OFS_STACK_LOW   6'h0d
`define CCR_OFS_STACK_HIGH  6'h0e
`define CCR_OFS_FLAGS       6'h0f

// ****************************************************************
// Reset values and keys
// ****************************************************************
`define CCR_GUARD_RESET     8'h00
`define CCR_FLAGS_RESET     8'h00
`define CCR_KEY_IO_UNLOCK   8'hd8
`define CCR_KEY_SELF_PROG   8'h9d

// ****************************************************************
// Field positions
// ****************************************************************
`define CCR_GUARD_IO_BIT    0
`define CCR_GUARD_PROG_BIT  1
`define CCR_FLAG_IRQ_EN     7
`define CCR_FLAG_TRANSFER   6
`define CCR_FLAG_HALF       5
`define CCR_FLAG_SIGN       4
`define CCR_FLAG_OVF        3
`define CCR_FLAG_NEG        2
`define CCR_FLAG_ZERO       1
`define CCR_FLAG_CARRY      0

// ****************************************************************
// Timing
// ****************************************************************
`define CCR_WINDOW_INSTR    4

`endif

// *** hdl/ccr_pkg.sv ***
/*
  Types shared by the CPU core control register files.
  Assumes ccr_defines.svh supplies the numeric constants.
*/
package ccr_pkg;

  typedef enum logic [1:0]
  {
    CCR_MODE_IDLE = 2'b00,
    CCR_MODE_IO   = 2'b01,
    CCR_MODE_PROG = 2'b11
  } ccr_guard_mode_t;

  typedef logic [7:0] ccr_byte_t;
  typedef logic [5:0] ccr_addr_t;

endpackage : ccr_pkg

// *** hdl/ccr_instr_window.sv ***
/*
  Instruction-counted window: opens on start, closes after LIMIT retired
  instructions or on kill. Assumes retire pulses once per executed instruction.
*/
`timescale 1ns/1ps
`default_nettype none

module ccr_instr_window
#(
  parameter int CNT_W = 3,
  parameter int LIMIT = 4
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // Control
  input  wire logic             start,
  input  wire logic             retire,
  input  wire logic             kill,
  // Status
  output logic                  open_reg,
  output logic                  open_next
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // ****************************************************************
  // Window counting
  // ****************************************************************
  // The key-writing instruction itself is not counted: start clears the count
  always_comb
  begin
    open_next = open_reg;
    cnt_next  = cnt_reg;
    if (start)
    begin
      open_next = 1'b1;
      cnt_next  = '0;
    end
    else if (open_reg)
    begin
      if (kill)
        open_next = 1'b0;
      else if (retire)
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == LAST)
          open_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      open_reg <= 1'b0;
      cnt_reg  <= '0;
    end
    else
    begin
      open_reg <= open_next;
      cnt_reg  <= cnt_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_window_ends_count: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    open_reg && retire && !kill && !start && cnt_reg == LAST |=> !open_reg)
    else $error("window still open after last counted instruction");

  a_window_opens: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    start |=> open_reg && cnt_reg == '0)
    else $error("window did not open on start");

endmodule : ccr_instr_window

`default_nettype wire

// *** hdl/ccr_core_regs.sv ***
/*
  CPU core control registers: configuration change guard, stack pointer
  with byte latch, and the flag register with global interrupt enable.
  Assumes the core issues single-cycle io_wr / io_rd strobes on one clock,
  pulses instr_retire once per executed instruction and drives the ALU
  flag results together with their update strobes.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ccr_defines.svh"

module ccr_core_regs
#(
  parameter int          STACK_BITS = 16,
  parameter logic [15:0] STACK_TOP  = 16'hffff
)
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // I/O register access
  input  wire ccr_pkg::ccr_addr_t io_addr,
  input  wire ccr_pkg::ccr_byte_t io_wdata,
  input  wire logic               io_wr,
  input  wire logic               io_rd,
  output ccr_pkg::ccr_byte_t      io_rdata,
  output logic                    io_wait,
  // Instruction events
  input  wire logic               instr_retire,
  input  wire logic               dmem_wr,
  input  wire logic               nvm_access,
  input  wire logic               sleep_exec,
  input  wire logic               set_irq_instr,
  input  wire logic               clear_irq_instr,
  input  wire logic               bit_store_instr,
  input  wire logic               bit_store_value,
  // ALU results
  input  wire logic               alu_update,
  input  wire logic               alu_arith,
  input  wire logic               alu_half,
  input  wire logic               alu_ovf,
  input  wire logic               alu_neg,
  input  wire logic               alu_zero,
  input  wire logic               alu_carry,
  // Stack pointer update by push, pop, call and return
  input  wire logic               core_stack_we,
  input  wire logic [15:0]        core_stack_value,
  // Status to the core
  output logic                    io_unlock,
  output logic                    self_prog_unlock,
  output logic                    irq_permit,
  output logic                    irq_enable,
  output logic                    transfer_flag,
  output ccr_pkg::ccr_byte_t      cpu_flags,
  output logic [15:0]             stack_pointer
);

  import ccr_pkg::*;

  localparam int WIN = `CCR_WINDOW_INSTR;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic addr_hit(input ccr_addr_t a, input ccr_addr_t ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Unimplemented stack bits are dropped on store and read back as zero
  function automatic logic [15:0] stack_mask(input logic [15:0] v);
    logic [15:0] m;
    m = '0;
    m[STACK_BITS-1:0] = v[STACK_BITS-1:0];
    stack_mask = m;
  endfunction : stack_mask

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic wr_guard;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic rd_low;
  logic key_io;
  logic key_prog;

  assign wr_guard = io_wr && addr_hit(io_addr, `CCR_OFS_GUARD);
  assign wr_low   = io_wr && addr_hit(io_addr, `CCR_OFS_STACK_LOW);
  assign wr_high  = io_wr && addr_hit(io_addr, `CCR_OFS_STACK_HIGH);
  assign wr_flags = io_wr && addr_hit(io_addr, `CCR_OFS_FLAGS);
  assign rd_low   = io_rd && addr_hit(io_addr, `CCR_OFS_STACK_LOW);
  assign key_io   = wr_guard && io_wdata == `CCR_KEY_IO_UNLOCK;
  assign key_prog = wr_guard && io_wdata == `CCR_KEY_SELF_PROG;

  // ****************************************************************
  // Configuration change guard
  // ****************************************************************
  ccr_guard_mode_t mode_reg;
  logic            guard_open_reg;
  logic            guard_open_next;
  logic            guard_kill;

  // A self-program unlock survives ordinary writes; only memory controller
  // access, sleep or an I/O key write ends it early
  always_comb
  begin
    guard_kill = nvm_access || sleep_exec;
    if (mode_reg == CCR_MODE_IO)
      guard_kill = guard_kill || io_wr || dmem_wr;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      mode_reg <= CCR_MODE_IDLE;
    else if (key_io)
      mode_reg <= CCR_MODE_IO;
    else if (key_prog)
      mode_reg <= CCR_MODE_PROG;
    else if (!guard_open_next)
      mode_reg <= CCR_MODE_IDLE;
  end

  ccr_instr_window
  #(
    .CNT_W (3),
    .LIMIT (WIN)
  )
  u_guard_window
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .start     (key_io || key_prog),
    .retire    (instr_retire),
    .kill      (guard_kill),
    .open_reg  (guard_open_reg),
    .open_next (guard_open_next)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      io_unlock        <= 1'b0;
      self_prog_unlock <= 1'b0;
    end
    else
    begin
      io_unlock        <= guard_open_next && (key_io ||
                          (!key_prog && mode_reg == CCR_MODE_IO));
      self_prog_unlock <= guard_open_next && (key_prog ||
                          (!key_io && mode_reg == CCR_MODE_PROG));
    end
  end

  // ****************************************************************
  // Stack pointer and byte latch
  // ****************************************************************
  logic [STACK_BITS-1:0] stack_reg;
  logic [7:0]            temp_reg;
  logic                  stack_open_reg;
  logic                  stack_open_next;
  logic [15:0]           stack_now;
  logic [15:0]           stack_pair;
  logic [15:0]           stack_core;

  // Masked views, so every store and every read drops the missing bits alike
  assign stack_now  = stack_mask(16'(stack_reg));
  assign stack_pair = stack_mask({io_wdata, temp_reg});
  assign stack_core = stack_mask(core_stack_value);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      temp_reg <= 8'h00;
    else if (wr_low)
      temp_reg <= io_wdata;
    else if (rd_low)
      temp_reg <= stack_now[15:8];
  end

  // A committed byte pair wins over a core update in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      stack_reg <= STACK_TOP[STACK_BITS-1:0];
    else if (wr_high)
      stack_reg <= stack_pair[STACK_BITS-1:0];
    else if (core_stack_we)
      stack_reg <= stack_core[STACK_BITS-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      stack_pointer <= stack_mask(STACK_TOP);
    else if (wr_high)
      stack_pointer <= stack_pair;
    else if (core_stack_we)
      stack_pointer <= stack_core;
  end

  // The low byte write itself must not end its own block window
  ccr_instr_window
  #(
    .CNT_W (3),
    .LIMIT (WIN)
  )
  u_stack_window
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .start     (wr_low),
    .retire    (instr_retire),
    .kill      (io_wr),
    .open_reg  (stack_open_reg),
    .open_next (stack_open_next)
  );

  // ****************************************************************
  // Flag register
  // ****************************************************************
  logic [7:0] flag_reg;
  logic [7:0] flag_next;

  // Instructions and register writes never coincide; the register write
  // is placed last so it is the final word if the core ever overlaps them
  always_comb
  begin
    flag_next = flag_reg;
    if (alu_update)
    begin
      flag_next[`CCR_FLAG_NEG]   = alu_neg;
      flag_next[`CCR_FLAG_ZERO]  = alu_zero;
      flag_next[`CCR_FLAG_CARRY] = alu_carry;
      if (alu_arith)
      begin
        flag_next[`CCR_FLAG_HALF] = alu_half;
        flag_next[`CCR_FLAG_OVF]  = alu_ovf;
      end
    end
    if (bit_store_instr)
      flag_next[`CCR_FLAG_TRANSFER] = bit_store_value;
    if (set_irq_instr)
      flag_next[`CCR_FLAG_IRQ_EN] = 1'b1;
    else if (clear_irq_instr)
      flag_next[`CCR_FLAG_IRQ_EN] = 1'b0;
    if (wr_flags)
      flag_next = io_wdata;
    // No interrupt entry or return input: the enable is software-owned
    flag_next[`CCR_FLAG_SIGN] = flag_next[`CCR_FLAG_NEG]
                                ^ flag_next[`CCR_FLAG_OVF];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      flag_reg      <= `CCR_FLAGS_RESET;
      cpu_flags     <= `CCR_FLAGS_RESET;
      irq_enable    <= 1'b0;
      transfer_flag <= 1'b0;
    end
    else
    begin
      flag_reg      <= flag_next;
      cpu_flags     <= flag_next;
      irq_enable    <= flag_next[`CCR_FLAG_IRQ_EN];
      transfer_flag <= flag_next[`CCR_FLAG_TRANSFER];
    end
  end

  // ****************************************************************
  // Interrupt gate and wait state
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      irq_permit <= 1'b0;
    else
      irq_permit <= flag_next[`CCR_FLAG_IRQ_EN]
                    && !guard_open_next
                    && !stack_open_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      io_wait <= 1'b0;
    else
      io_wait <= wr_flags
                 && io_wdata[`CCR_FLAG_IRQ_EN] != flag_reg[`CCR_FLAG_IRQ_EN];
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped addresses read zero; data appear the cycle after io_rd
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      io_rdata <= 8'h00;
    else if (io_rd)
    begin
      case (io_addr)
        `CCR_OFS_GUARD:      io_rdata <= {6'h00, self_prog_unlock, io_unlock};
        `CCR_OFS_STACK_LOW:  io_rdata <= stack_now[7:0];
        `CCR_OFS_STACK_HIGH: io_rdata <= temp_reg;
        `CCR_OFS_FLAGS:      io_rdata <= flag_reg;
        default:             io_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_guard_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    io_rd && io_addr == `CCR_OFS_GUARD |=> io_rdata[7:2] == 6'h00)
    else $error("guard upper bits not zero");

  a_key_io_opens: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    key_io |=> io_unlock && !self_prog_unlock)
    else $error("io key did not unlock");

  a_key_prog_opens: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    key_prog |=> self_prog_unlock && !io_unlock)
    else $error("self program key did not unlock");

  a_unlock_blocks_irq: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (io_unlock || self_prog_unlock) |-> !irq_permit)
    else $error("interrupt permitted during unlock");

  a_io_write_ends: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    io_unlock && dmem_wr && !wr_guard |=> !io_unlock)
    else $error("io unlock survived a data write");

  a_stack_reset_top: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(rst_b) |-> stack_pointer == stack_mask(STACK_TOP))
    else $error("stack pointer not at top after reset");

  a_stack_pair_commit: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_low ##1 (wr_high && !wr_low)
    |=> stack_pointer == stack_mask({$past(io_wdata), $past(io_wdata, 2)}))
    else $error("byte pair not committed together");

  a_stack_read_latch: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    rd_low && !wr_low ##1 (io_rd && io_addr == `CCR_OFS_STACK_HIGH && !wr_high)
    |=> io_rdata == $past(stack_pointer[15:8], 2))
    else $error("high byte read not from latch");

  a_low_write_blocks: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_low |=> !irq_permit)
    else $error("interrupt permitted after low byte write");

  a_sign_is_xor: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    cpu_flags[`CCR_FLAG_SIGN] == (cpu_flags[`CCR_FLAG_NEG] ^ cpu_flags[`CCR_FLAG_OVF]))
    else $error("sign flag not negative xor overflow");

  a_enable_wait: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    wr_flags && io_wdata[7] != irq_enable |=> io_wait ##1 !io_wait)
    else $error("enable change without one wait cycle");

  a_enable_gates: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !irq_enable |-> !irq_permit)
    else $error("interrupt permitted with enable clear");

endmodule : ccr_core_regs

`default_nettype wire

// *** bench/ccr_core_model.sv ***
/*
  Processor core side of the control registers: single-cycle byte
  writes and reads on the I/O bus, and instruction retire pulses.
  Assumes one clock; all drives are made by NBA on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module ccr_core_model
(
  // Clock
  input  wire logic                clk_sys,
  // Register bus
  output ccr_pkg::ccr_addr_t       io_addr,
  output ccr_pkg::ccr_byte_t       io_wdata,
  output logic                     io_wr,
  output logic                     io_rd,
  input  wire ccr_pkg::ccr_byte_t  io_rdata,
  // Instruction stream
  output logic                     instr_retire
);
  import ccr_pkg::*;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial
  begin
    io_addr      = 6'h3f;
    io_wdata     = 8'h00;
    io_wr        = 1'h0;
    io_rd        = 1'h0;
    instr_retire = 1'h0;
  end

  // Released lines are inverted so stale values are never mistaken
  task automatic wr(input ccr_addr_t a, input ccr_byte_t d);
    @(posedge clk_sys);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'h1;
    @(posedge clk_sys);
    io_wr    <= 1'h0;
    io_addr  <= ~a;
    io_wdata <= ~d;
  endtask : wr

  task automatic rd(input ccr_addr_t a, output ccr_byte_t d);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd   <= 1'h1;
    @(posedge clk_sys);
    io_rd   <= 1'h0;
    io_addr <= ~a;
    #1;
    d = io_rdata;
  endtask : rd

  // Protected access must land inside the retire count
  task automatic ret(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      instr_retire <= 1'h1;
    end
    @(posedge clk_sys);
    instr_retire <= 1'h0;
  endtask : ret

endmodule : ccr_core_model

`default_nettype wire

// *** bench/cpu_core_control_registers_test.sv ***
/*
  Self-checking bench for the core control registers, with a core
  bus model. Assumes a 10-bit stack pointer with top 0x3ff.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_core_control_registers_test;
  import ccr_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_sys = 1'h0;
  logic        rst_b   = 1'h0;
  ccr_addr_t   io_addr;
  ccr_byte_t   io_wdata, io_rdata, cpu_flags, rb;
  logic        io_wr, io_rd, io_wait, instr_retire;
  logic        io_unlock, self_prog_unlock, irq_permit;
  logic        irq_enable, transfer_flag;
  logic [15:0] stack_pointer;
  // Event strobes and one shared data word for them
  logic [7:0]  ev  = 8'h00;
  logic [15:0] dat = 16'h0000;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #2 clk_sys = ~clk_sys;

  ccr_core_model u_ccr_core_model
  (
    .clk_sys, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .instr_retire
  );

  ccr_core_regs #(.STACK_BITS(10), .STACK_TOP(16'h03ff)) u_ccr_core_regs
  (
    .clk_sys, .rst_b, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .io_wait, .instr_retire,
    .dmem_wr(ev[0]), .nvm_access(ev[1]), .sleep_exec(ev[2]),
    .set_irq_instr(ev[3]), .clear_irq_instr(ev[4]),
    .bit_store_instr(ev[5]), .bit_store_value(dat[0]),
    .alu_update(ev[6]), .alu_arith(dat[5]), .alu_half(dat[4]),
    .alu_ovf(dat[3]), .alu_neg(dat[2]), .alu_zero(dat[1]),
    .alu_carry(dat[0]), .core_stack_we(ev[7]), .core_stack_value(dat),
    .io_unlock, .self_prog_unlock, .irq_permit, .irq_enable,
    .transfer_flag, .cpu_flags, .stack_pointer
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input ccr_addr_t a, input ccr_byte_t d);
    u_ccr_core_model.wr(a, d);
    #1;
  endtask : w

  task automatic r(input ccr_addr_t a);
    u_ccr_core_model.rd(a, rb);
  endtask : r

  task automatic rt(input int n);
    u_ccr_core_model.ret(n);
    #1;
  endtask : rt

  task automatic pul(input logic [7:0] m, input logic [15:0] d);
    @(posedge clk_sys);
    ev  <= m;
    dat <= d;
    @(posedge clk_sys);
    ev  <= 8'h00;
    #1;
  endtask : pul

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(stack_pointer, 16'h03ff);
    r(6'h0d);
    chk(rb, 8'hff);
    r(6'h0e);
    chk(rb, 8'h03);
    r(6'h0f);
    chk(rb, 8'h00);
    r(6'h20);
    chk(rb, 8'h00);
  endtask : t_reset

  task automatic t_guard;
    pul(8'h08, 16'h0000);
    chk(irq_permit, 1'h1);
    w(6'h04, 8'hff);
    r(6'h04);
    chk(rb, 8'h00);
    w(6'h04, 8'hd8);
    chk(io_unlock, 1'h1);
    chk(irq_permit, 1'h0);
    r(6'h04);
    chk(rb, 8'h01);
    rt(3);
    chk(io_unlock, 1'h1);
    rt(1);
    chk(io_unlock, 1'h0);
    chk(irq_permit, 1'h1);
    w(6'h04, 8'hd8);
    pul(8'h01, 16'h0000);
    chk(io_unlock, 1'h0);
    w(6'h04, 8'hd8);
    pul(8'h04, 16'h0000);
    chk(io_unlock, 1'h0);
    w(6'h04, 8'hd8);
    w(6'h20, 8'h55);
    chk(io_unlock, 1'h0);
    w(6'h04, 8'h9d);
    chk(self_prog_unlock, 1'h1);
    r(6'h04);
    chk(rb, 8'h02);
    pul(8'h01, 16'h0000);
    chk(self_prog_unlock, 1'h1);
    pul(8'h02, 16'h0000);
    chk(self_prog_unlock, 1'h0);
  endtask : t_guard

  task automatic t_stack;
    w(6'h0d, 8'h34);
    chk(irq_permit, 1'h0);
    chk(stack_pointer, 16'h03ff);
    w(6'h0e, 8'hfe);
    chk(stack_pointer, 16'h0234);
    chk(irq_permit, 1'h1);
    w(6'h0d, 8'h78);
    rt(3);
    chk(irq_permit, 1'h0);
    rt(1);
    chk(irq_permit, 1'h1);
    r(6'h0d);
    chk(rb, 8'h34);
    pul(8'h80, 16'h0155);
    r(6'h0e);
    chk(rb, 8'h02);
    r(6'h0d);
    chk(rb, 8'h55);
    r(6'h0e);
    chk(rb, 8'h01);
  endtask : t_stack

  task automatic t_flags;
    w(6'h0f, 8'h00);
    chk(io_wait, 1'h1);
    chk(irq_permit, 1'h0);
    w(6'h0f, 8'h00);
    chk(io_wait, 1'h0);
    pul(8'h08, 16'h0000);
    chk(irq_enable, 1'h1);
    pul(8'h10, 16'h0000);
    chk(irq_enable, 1'h0);
    w(6'h0f, 8'h80);
    chk(irq_enable, 1'h1);
    pul(8'h20, 16'h0001);
    chk(transfer_flag, 1'h1);
    pul(8'h40, 16'h003b);
    chk(cpu_flags, 8'hfb);
    pul(8'h40, 16'h001c);
    chk(cpu_flags, 8'hec);
    w(6'h0f, 8'h1c);
    chk(cpu_flags, 8'h0c);
    chk(transfer_flag, 1'h0);
  endtask : t_flags

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  // Whole run is about a hundred cycles; the ceiling leaves ample slack
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_guard();
    t_stack();
    t_flags();
    wrap_up();
  end

endmodule : cpu_core_control_registers_test

`default_nettype wire
